// ==== btss_pkg.sv ====
/*
 * Constants, types and field layout for the bit-test, skip-when-one executor.
 * Assumes a 16-bit instruction word and a 14-bit data address (6-bit bank, 8-bit offset).
 */
`default_nettype none
package btss_pkg;
    localparam int unsigned IW = 16;
    localparam int unsigned AW = 14;
    localparam int unsigned BW = 6;
    localparam int unsigned FW = 8;
    localparam int unsigned DW = 8;

    localparam int unsigned OPC_HI = 15;
    localparam int unsigned OPC_LO = 12;
    localparam int unsigned BIT_HI = 11;
    localparam int unsigned BIT_LO = 9;
    localparam int unsigned ACC_POS = 8;
    localparam int unsigned F_HI = 7;
    localparam int unsigned F_LO = 0;

    localparam logic [3:0]      OPC_BIT_TEST_SKIP_WHEN_ONE = 4'hA;
    localparam logic [FW-1:0]   INDEXED_LIMIT              = 8'h5F;
    localparam logic [FW-1:0]   ACCESS_SPLIT               = 8'h60;
    localparam logic [BW-1:0]   ACCESS_LOW_BANK            = 6'h00;
    localparam logic [BW-1:0]   ACCESS_HIGH_BANK           = 6'h3F;
    localparam logic [1:0]      QUARTERS_LAST              = 2'h3;
    localparam logic [1:0]      Q1_CODE                    = 2'h0;
    localparam logic [1:0]      Q2_CODE                    = 2'h1;
    localparam logic [1:0]      Q3_CODE                    = 2'h2;
    localparam logic [1:0]      Q4_CODE                    = 2'h3;
    localparam logic [AW-1:0]   ADDR_RESET                 = 14'h0000;
    localparam logic [1:0]      WORDS_NONE                 = 2'h0;
    localparam logic [1:0]      WORDS_ONE                  = 2'h1;

    typedef enum logic [1:0] {
        BTSS_IDLE  = 2'b00,
        BTSS_EXEC  = 2'b01,
        BTSS_FLUSH = 2'b10
    } btss_state_t;
endpackage : btss_pkg
`default_nettype wire

// ==== btss_q_if.sv ====
/*
 * Quarter-phase enables shared between the phase generator and the executor.
 * Assumes one clock; each enable is a one-cycle pulse.
 */
`timescale 1ns/10ps
`default_nettype none
interface btss_q_if;
    logic q1;
    logic q2;
    logic q3;
    logic q4;
    modport gen (output q1, output q2, output q3, output q4);
    modport use_q (input q1, input q2, input q3, input q4);
endinterface : btss_q_if
`default_nettype wire

// ==== btss_qgen.sv ====
/*
 * Quarter-phase divider: splits the core clock into four rotating enables.
 * Assumes ref_clk_i is the core clock; one quarter lasts one clock.
 */
`timescale 1ns/10ps
`default_nettype none
module btss_qgen
    import btss_pkg::*;
(
    input  wire logic ref_clk_i,
    input  wire logic rst_b_i,
    btss_q_if.gen     q
);
    logic [1:0] ph_q;
    logic [1:0] ph_d;

    always_comb begin
        ph_d = ph_q + 2'h1;
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ph_q <= Q1_CODE;
        end else begin
            ph_q <= ph_d;
        end
    end

    assign q.q1 = (ph_q == Q1_CODE);
    assign q.q2 = (ph_q == Q2_CODE);
    assign q.q3 = (ph_q == Q3_CODE);
    assign q.q4 = (ph_q == Q4_CODE);
endmodule : btss_qgen
`default_nettype wire

// ==== btss_exec.sv ====
/*
 * Executor for the bit-test, skip-when-one instruction: decode, operand
 * address forming, data read, bit test and flush of skipped words.
 * Assumes data memory answers a read one clock after rd_en_o, and that the
 * fetch stage reports the word length of the prefetched instruction.
 * One instruction cycle is four clocks, one per quarter: Q1 decodes, Q2 reads,
 * Q3 tests the bit and Q4 decides. A skip adds one full no-operation cycle per
 * word of the skipped instruction, so the cost is one, two, three or four cycles.
 * Nothing is ever written back and no status flag is driven from here.
 */
`timescale 1ns/10ps
`default_nettype none
module btss_exec
    import btss_pkg::*;
(
    input  wire logic          ref_clk_i,
    input  wire logic          rst_b_i,
    input  wire logic          instr_valid_i,
    input  wire logic [IW-1:0] instr_i,
    input  wire logic [1:0]    next_words_i,
    input  wire logic          ext_set_en_i,
    input  wire logic [BW-1:0] bank_selection_register_i,
    input  wire logic [AW-1:0] index_base_i,
    input  wire logic [DW-1:0] rd_data_i,
    output logic               ready_o,
    output logic               busy_o,
    output logic               rd_en_o,
    output logic [AW-1:0]      rd_addr_o,
    output logic               skip_o,
    output logic               discard_o,
    output logic               no_operation_o,
    output logic               done_o
);
    ////////////////////////////////////////////////////////////////////////////
    // quarter phases

    btss_q_if qph ();

    btss_qgen u_qgen (
        .ref_clk_i (ref_clk_i),
        .rst_b_i   (rst_b_i),
        .q         (qph)
    );

    ////////////////////////////////////////////////////////////////////////////
    // decode

    logic          hit;
    logic [2:0]    bit_sel;
    logic          acc_bit;
    logic [FW-1:0] f_addr;
    logic [AW-1:0] eff_addr;

    assign hit     = instr_valid_i && (instr_i[OPC_HI:OPC_LO] == OPC_BIT_TEST_SKIP_WHEN_ONE);
    assign bit_sel = instr_i[BIT_HI:BIT_LO];
    assign acc_bit = instr_i[ACC_POS];
    assign f_addr  = instr_i[F_HI:F_LO];

    // bank-access one wins; indexed offsets only ever replace the access bank
    always_comb begin
        if (acc_bit) begin
            eff_addr = {bank_selection_register_i, f_addr};
        end else if (ext_set_en_i && (f_addr <= INDEXED_LIMIT)) begin
            eff_addr = index_base_i + {{(AW-FW){1'b0}}, f_addr};
        end else if (f_addr < ACCESS_SPLIT) begin
            eff_addr = {ACCESS_LOW_BANK, f_addr};
        end else begin
            eff_addr = {ACCESS_HIGH_BANK, f_addr};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencer

    btss_state_t   st_q;
    btss_state_t   st_d;
    logic [2:0]    bit_q;
    logic [2:0]    bit_d;
    logic [AW-1:0] addr_q;
    logic [AW-1:0] addr_d;
    logic          rd_q;
    logic          rd_d;
    logic          skip_q;
    logic          skip_d;
    logic          disc_q;
    logic          disc_d;
    logic          nop_q;
    logic          nop_d;
    logic          done_q;
    logic          done_d;
    logic [1:0]    left_q;
    logic [1:0]    left_d;
    logic [1:0]    words_q;
    logic [1:0]    words_d;

    always_comb begin
        st_d    = st_q;
        bit_d   = bit_q;
        addr_d  = addr_q;
        rd_d    = 1'b0;
        skip_d  = skip_q;
        disc_d  = 1'b0;
        nop_d   = nop_q;
        done_d  = 1'b0;
        unique case (st_q)
            BTSS_IDLE: begin
                if (qph.q1 && hit) begin
                    // decode in Q1, address is held for the Q2 read
                    st_d   = BTSS_EXEC;
                    bit_d  = bit_sel;
                    addr_d = eff_addr;
                    rd_d   = 1'b1;
                    skip_d = 1'b0;
                    nop_d  = 1'b0;
                end
            end
            BTSS_EXEC: begin
                if (qph.q3) begin
                    skip_d = rd_data_i[bit_q];
                end
                if (qph.q4) begin
                    // nothing is written back and no flag is touched
                    if (skip_q) begin
                        st_d   = BTSS_FLUSH;
                        disc_d = 1'b1;
                        nop_d  = 1'b1;
                    end else begin
                        st_d   = BTSS_IDLE;
                        done_d = 1'b1;
                    end
                end
            end
            BTSS_FLUSH: begin
                if (qph.q4) begin
                    if (left_q == WORDS_ONE) begin
                        st_d   = BTSS_IDLE;
                        nop_d  = 1'b0;
                        done_d = 1'b1;
                    end else begin
                        disc_d = 1'b1;
                    end
                end
            end
            default: begin
                st_d = BTSS_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_q    <= BTSS_IDLE;
            bit_q   <= 3'h0;
            addr_q  <= ADDR_RESET;
            rd_q    <= 1'b0;
            skip_q  <= 1'b0;
            disc_q  <= 1'b0;
            nop_q   <= 1'b0;
            done_q  <= 1'b0;
        end else begin
            st_q    <= st_d;
            bit_q   <= bit_d;
            addr_q  <= addr_d;
            rd_q    <= rd_d;
            skip_q  <= skip_d;
            disc_q  <= disc_d;
            nop_q   <= nop_d;
            done_q  <= done_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // flush counter: words of the skipped instruction still to be thrown away

    logic [1:0]    words_in;
    logic          cnt_load;
    logic          cnt_step;

    // a zero length from fetch counts as one word, so a skip always flushes something
    assign words_in = (next_words_i == WORDS_NONE) ? WORDS_ONE : next_words_i;
    assign cnt_load = (st_q == BTSS_EXEC) && qph.q4 && skip_q;
    assign cnt_step = (st_q == BTSS_FLUSH) && qph.q4;

    always_comb begin
        words_d = words_q;
        left_d  = left_q;
        if ((st_q == BTSS_EXEC) && qph.q2) begin
            // length of the prefetched word, known once it is fetched
            words_d = words_in;
        end
        if (cnt_load) begin
            left_d = words_q;
        end else if (cnt_step) begin
            left_d = left_q - WORDS_ONE;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            words_q <= WORDS_NONE;
            left_q  <= WORDS_NONE;
        end else begin
            words_q <= words_d;
            left_q  <= left_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    // ready is combinational so the Q1 that shows done_o can take the next word

    assign ready_o        = (st_q == BTSS_IDLE) && qph.q1;
    assign busy_o         = (st_q != BTSS_IDLE);
    assign rd_en_o        = rd_q;
    assign rd_addr_o      = addr_q;
    assign skip_o         = skip_q;
    assign discard_o      = disc_q;
    assign no_operation_o = nop_q;
    assign done_o         = done_q;
endmodule : btss_exec
`default_nettype wire

// ==== btss_exec_monitor.sv ====
/* Checker for the skip-when-one executor.
   Sees only the executor ports; bound to it at the foot of this file. */
`timescale 1ns/10ps
`default_nettype none
module btss_exec_monitor
    import btss_pkg::*;
(
    input wire logic          ref_clk_i,
    input wire logic          rst_b_i,
    input wire logic          ready_o,
    input wire logic          busy_o,
    input wire logic          no_operation_o,
    input wire logic          instr_valid_i,
    input wire logic [IW-1:0] instr_i,
    input wire logic          ext_set_en_i,
    input wire logic [BW-1:0] bank_selection_register_i,
    input wire logic [AW-1:0] index_base_i,
    input wire logic [DW-1:0] rd_data_i,
    input wire logic          rd_en_o,
    input wire logic [AW-1:0] rd_addr_o,
    input wire logic          skip_o,
    input wire logic          discard_o,
    input wire logic          done_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);
    logic          take;
    logic          opc_ok;
    logic          acc;
    logic          idx;
    logic [FW-1:0] f_w;
    logic [2:0]    bit_q;
    assign opc_ok = instr_i[OPC_HI:OPC_LO] == OPC_BIT_TEST_SKIP_WHEN_ONE;
    assign take   = ready_o && instr_valid_i && opc_ok;
    assign f_w    = instr_i[F_HI:F_LO];
    assign acc    = instr_i[ACC_POS];
    assign idx    = !acc && ext_set_en_i && f_w <= INDEXED_LIMIT;
    // bit index kept from the decode slot, the word may change afterwards
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) bit_q <= 3'h0;
        else if (take) bit_q <= instr_i[BIT_HI:BIT_LO];
    end
    chk_read_after_take: assert property (take |=> rd_en_o)
        else $error("read not issued after decode");
    chk_other_opcode: assert property (ready_o && instr_valid_i && !opc_ok |=> !rd_en_o)
        else $error("other opcode started a read");
    chk_bit_one_skips: assert property (rd_en_o ##1 rd_data_i[bit_q] |=> skip_o)
        else $error("set bit did not skip");
    chk_bit_zero_runs: assert property (rd_en_o ##1 !rd_data_i[bit_q] |=> !skip_o)
        else $error("clear bit skipped");
    chk_nop_on_discard: assert property (discard_o |-> no_operation_o && busy_o)
        else $error("discarded word without no-operation cycle");
    chk_done_ends_nop: assert property (done_o |-> !no_operation_o && !busy_o)
        else $error("no-operation or busy still high at done");
    chk_noskip_done: assert property (rd_en_o ##2 !skip_o |=> done_o && !discard_o)
        else $error("no-skip case not one cycle");
    chk_skip_flush: assert property (rd_en_o ##2 skip_o |=> discard_o)
        else $error("skip did not discard the prefetched word");
    chk_flush_spacing: assert property (discard_o |=> !discard_o [*3] ##1 (discard_o || done_o))
        else $error("flush cycles not four clocks apart");
    chk_bank_addr: assert property (rd_en_o && $past(acc) |->
        rd_addr_o == {$past(bank_selection_register_i), $past(f_w)}) else $error("banked address");
    chk_access_addr: assert property (rd_en_o && !$past(acc) && !$past(idx) |->
        rd_addr_o == {($past(f_w) < ACCESS_SPLIT) ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK, $past(f_w)})
        else $error("access bank address");
    chk_indexed_addr: assert property (rd_en_o && $past(idx) |->
        rd_addr_o == $past(index_base_i) + AW'($past(f_w))) else $error("indexed address");
    cover property (rd_en_o ##2 skip_o);
    cover property (rd_en_o ##2 !skip_o);
    cover property (discard_o ##4 discard_o ##4 discard_o);
endmodule : btss_exec_monitor
bind btss_exec btss_exec_monitor i_btss_exec_monitor (.ref_clk_i, .rst_b_i, .ready_o,
    .busy_o, .no_operation_o,
    .instr_valid_i, .instr_i, .ext_set_en_i, .bank_selection_register_i, .index_base_i,
    .rd_data_i, .rd_en_o, .rd_addr_o, .skip_o, .discard_o, .done_o);
`default_nettype wire

// ==== btss_dmem_model.sv ====
/* Data-memory model on the executor read port.
   Answers one clock after rd_en_i; content is a fixed mix of the address. */
`timescale 1ns/10ps
`default_nettype none
module btss_dmem_model
    import btss_pkg::*;
(
    input  wire logic          ref_clk_i,
    input  wire logic          rst_b_i,
    input  wire logic          rd_en_i,
    input  wire logic [AW-1:0] rd_addr_i,
    output var  logic [DW-1:0] rd_data_o
);
    // outside a read the bus flips every clock so stale data never looks valid
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) rd_data_o <= 8'h00;
        else if (rd_en_i) rd_data_o <= rd_addr_i[7:0] ^ {2'h0, rd_addr_i[13:8]};
        else rd_data_o <= ~rd_data_o;
    end
endmodule : btss_dmem_model
`default_nettype wire

// ==== tb_top.sv ====
/* Self-checking bench for the skip-when-one executor.
   Inputs change 1 ns after each rising edge; data comes from the memory model. */
`timescale 1ns/10ps
`default_nettype none
module tb_top import btss_pkg::*;;
    logic          ref_clk_i = 1'b0;
    logic          rst_b_i = 1'b0;
    logic          instr_valid_i = 1'b0;
    logic          ext_set_en_i = 1'b0;
    logic [IW-1:0] instr_i = 16'h0000;
    logic [1:0]    next_words_i = 2'h1;
    logic [BW-1:0] bank_selection_register_i = 6'h00;
    logic [AW-1:0] index_base_i = 14'h0000;
    logic [DW-1:0] rd_data_i;
    logic          ready_o, busy_o, rd_en_o, skip_o, discard_o, no_operation_o, done_o;
    logic [AW-1:0] rd_addr_o;
    int            miscompares = 0;
    int            comparisons = 0;
    initial begin
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    btss_exec i_btss_exec (.ref_clk_i, .rst_b_i, .instr_valid_i, .instr_i, .next_words_i,
        .ext_set_en_i, .bank_selection_register_i, .index_base_i, .rd_data_i, .ready_o,
        .busy_o, .rd_en_o, .rd_addr_o, .skip_o, .discard_o, .no_operation_o, .done_o);
    btss_dmem_model i_btss_dmem_model (.ref_clk_i, .rst_b_i, .rd_en_i(rd_en_o),
        .rd_addr_i(rd_addr_o), .rd_data_o(rd_data_i));
    task automatic give_verdict;
        if (miscompares == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : give_verdict
    task automatic bad(input string m);
        miscompares++;
        $display("mismatch at %0t: %s", $time, m);
    endtask : bad
    task automatic wait_ready;
        int n;
        n = 0;
        while (ready_o !== 1'b1 && n < 8) begin
            @(posedge ref_clk_i);
            #1 n++;
        end
        if (ready_o !== 1'b1) begin
            bad("ready timeout");
            give_verdict();
        end
    endtask : wait_ready
    task automatic run(input logic [15:0] ins, input logic [1:0] w, input logic [13:0] ea,
                       input logic es);
        int n;
        int d;
        int p;
        int r;
        wait_ready();
        instr_i = ins;
        next_words_i = w;
        instr_valid_i = 1'b1;
        @(posedge ref_clk_i);
        #1 instr_valid_i = 1'b0;
        n = 1;
        d = 0;
        p = 0;
        r = 0;
        comparisons += 7;
        if (rd_en_o !== 1'b1 || rd_addr_o !== ea) bad("read address");
        if (busy_o !== 1'b1) bad("busy not raised after decode");
        while (done_o !== 1'b1 && n < 20) begin
            @(posedge ref_clk_i);
            #1 n++;
            d += (discard_o === 1'b1);
            p += (no_operation_o === 1'b1);
            r += (rd_en_o === 1'b1);
        end
        if (done_o !== 1'b1) begin
            bad("done timeout");
            give_verdict();
        end else begin
            if (skip_o !== es) bad("skip decision");
            if (n != (es ? 4 + 4 * w : 4)) bad("cycle count");
            if (d != (es ? w : 0)) bad("discard count");
            if (p != (es ? 4 * w : 0) || busy_o !== 1'b0) bad("no-operation span");
            if (r != 0) bad("more than one read");
        end
    endtask : run
    task automatic s_wrong_opcode;
        wait_ready();
        instr_i = 16'hBA21;
        instr_valid_i = 1'b1;
        repeat (4) begin
            @(posedge ref_clk_i);
            #1 comparisons++;
            if (rd_en_o !== 1'b0 || busy_o !== 1'b0) bad("other opcode taken");
        end
        instr_valid_i = 1'b0;
    endtask : s_wrong_opcode
    task automatic s_access_low;
        run(16'hA221, 2'h3, 14'h0021, 1'b0);
    endtask : s_access_low
    task automatic s_banked;
        bank_selection_register_i = 6'h05;
        run(16'hA110, 2'h1, 14'h0510, 1'b1);
    endtask : s_banked
    task automatic s_access_high;
        ext_set_en_i = 1'b1;
        run(16'hAEF0, 2'h2, 14'h3FF0, 1'b1);
    endtask : s_access_high
    task automatic s_indexed;
        index_base_i = 14'h0100;
        run(16'hAC5F, 2'h3, 14'h015F, 1'b1);
    endtask : s_indexed
    task automatic s_banked_ext;
        run(16'hA310, 2'h2, 14'h0510, 1'b0);
    endtask : s_banked_ext
    initial begin
        repeat (8) @(posedge ref_clk_i);
        #1 rst_b_i = 1'b1;
        s_wrong_opcode();
        s_access_low();
        s_banked();
        s_access_high();
        s_indexed();
        s_banked_ext();
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
